// ==== pkg/fbpe_pkg.sv ====
package fbpe_pkg;
    localparam int FLASH_BYTES = 98304;
    localparam int BLOCK_BYTES = 1024;
    localparam int WORD_BYTES = 4;
    localparam int NUM_WORDS = FLASH_BYTES / WORD_BYTES;
    localparam int NUM_BLOCKS = FLASH_BYTES / BLOCK_BYTES;
    localparam int NUM_GRAN = NUM_BLOCKS / 2;
    localparam int WORDS_PER_BLOCK = BLOCK_BYTES / WORD_BYTES;
    localparam int WADDR_W = 15;
    localparam int BLK_W = 7;
    localparam int GRAN_W = 6;
    localparam int BOFF_W = 8;
    localparam int GRAN_LSB = 9;
    localparam int BLK_LSB = 8;
    localparam logic [31:0] ERASED_WORD = 32'hFFFF_FFFF;
    localparam logic [BOFF_W-1:0] LAST_BOFF = 8'hFF;
    localparam logic [NUM_GRAN-1:0] PROT_RESET = 48'h0000_0000_0000;

    typedef enum logic [1:0] {
        FBPE_IDLE = 2'b00,
        FBPE_ERASE = 2'b01
    } fbpe_state_t;

    typedef enum logic [1:0] {
        FBPE_SRC_FETCH = 2'b00,
        FBPE_SRC_DATA = 2'b01,
        FBPE_SRC_DEBUG = 2'b10
    } fbpe_src_t;
endpackage

// ==== core/fbpe_array.sv ====
`timescale 1ns/1ps
`default_nettype none
module fbpe_array (
    input wire logic mclk,
    input wire logic [fbpe_pkg::WADDR_W-1:0] raddr,
    output logic [31:0] rdata,
    input wire logic we,
    input wire logic [fbpe_pkg::WADDR_W-1:0] waddr,
    input wire logic [31:0] wdata
);
    import fbpe_pkg::*;

    logic [31:0] mem [NUM_WORDS];

    always_ff @(posedge mclk) begin
        if (we) begin
            mem[waddr] <= wdata;
        end
        rdata <= mem[raddr];
    end
endmodule
`default_nettype wire

// ==== core/fbpe_flash_ctrl.sv ====
// Operation
// R1 - 96 KB array, 1 KB blocks, independent erase
// R2 - erase leaves whole block all ones
// R3 - protection held per 2 KB block pair
// R4 - granule may be read-only or execute-only
// R5 - read-only refuses erase and program
// R6 - execute-only refuses erase and program
// R7 - execute-only readable by instruction fetch only
// R8 - reads complete in one cycle
// R9 - refused access flags violation, flash untouched; blocked program/erase flagged only when idle, program only if er_req low
`timescale 1ns/1ps
`default_nettype none
module fbpe_flash_ctrl (
    input wire logic mclk,
    input wire logic reset,
    input wire logic rd_req,
    input wire logic [1:0] rd_src,
    input wire logic [fbpe_pkg::WADDR_W-1:0] rd_addr,
    output logic rd_valid,
    output logic [31:0] rd_data,
    output logic rd_denied,
    input wire logic pg_req,
    input wire logic [fbpe_pkg::WADDR_W-1:0] pg_addr,
    input wire logic [31:0] pg_data,
    input wire logic er_req,
    input wire logic [fbpe_pkg::BLK_W-1:0] er_block,
    output logic busy,
    output logic done,
    input wire logic prot_wr,
    input wire logic [fbpe_pkg::GRAN_W-1:0] prot_gran,
    input wire logic prot_ro,
    input wire logic prot_xo,
    output logic [fbpe_pkg::NUM_GRAN-1:0] ro_map,
    output logic [fbpe_pkg::NUM_GRAN-1:0] xo_map,
    output logic viol,
    input wire logic viol_clr
);
    import fbpe_pkg::*;

    typedef struct packed {
        fbpe_state_t st;
        logic [BLK_W-1:0] blk;
        logic [BOFF_W-1:0] off;
        logic [NUM_GRAN-1:0] ro;
        logic [NUM_GRAN-1:0] xo;
        logic viol;
        logic done;
        logic rvalid;
        logic rmask;
    } fbpe_regs_t;

    fbpe_regs_t r, next_r;
    logic [31:0] arr_rdata;
    logic arr_we;
    logic [WADDR_W-1:0] arr_waddr;
    logic [31:0] arr_wdata;
    logic rd_blocked;
    logic pg_blocked;
    logic er_blocked;

    function automatic logic [GRAN_W-1:0] gran_of(input logic [WADDR_W-1:0] a);
        return a[WADDR_W-1:GRAN_LSB];
    endfunction

    function automatic logic in_range(input logic [WADDR_W-1:0] a);
        return 32'(a) < NUM_WORDS;
    endfunction

    always_comb begin
        // fetch may read execute-only; data and debug may not
        // range guard keeps granule index inside the maps
        rd_blocked = in_range(rd_addr) && r.xo[gran_of(rd_addr)]
            && (rd_src != FBPE_SRC_FETCH); // [R7]
        pg_blocked = in_range(pg_addr)
            && (r.ro[gran_of(pg_addr)] || r.xo[gran_of(pg_addr)]); // [R5] [R6]
        er_blocked = (32'(er_block) < NUM_BLOCKS)
            && (r.ro[er_block[BLK_W-1:1]] || r.xo[er_block[BLK_W-1:1]]); // [R3] [R5] [R6]
    end

    always_comb begin
        next_r = r;
        next_r.done = 1'b0;
        arr_we = 1'b0;
        arr_waddr = pg_addr;
        arr_wdata = pg_data;
        next_r.rvalid = rd_req && in_range(rd_addr); // [R8]
        next_r.rmask = rd_blocked;
        if (prot_wr) begin
            next_r.ro[prot_gran] = prot_ro; // [R4]
            next_r.xo[prot_gran] = prot_xo;
        end
        case (r.st)
            FBPE_IDLE: begin
                if (er_req && 32'(er_block) < NUM_BLOCKS) begin
                    if (!er_blocked) begin
                        next_r.st = FBPE_ERASE; // [R1]
                        next_r.blk = er_block;
                        next_r.off = '0;
                    end
                end else if (pg_req && in_range(pg_addr) && !pg_blocked) begin
                    // written as given; caller keeps the ones-to-zeros rule
                    arr_we = 1'b1;
                    arr_wdata = pg_data & ERASED_WORD;
                    next_r.done = 1'b1;
                end
            end
            FBPE_ERASE: begin
                arr_we = 1'b1; // [R2]
                arr_waddr = {r.blk, r.off};
                arr_wdata = ERASED_WORD;
                next_r.off = r.off + 8'h01;
                if (r.off == LAST_BOFF) begin
                    next_r.st = FBPE_IDLE;
                    next_r.done = 1'b1;
                end
            end
            default: begin
                next_r.st = FBPE_IDLE;
            end
        endcase
        // set beats clear so a violation is never lost
        if (viol_clr) begin
            next_r.viol = 1'b0;
        end
        if ((rd_req && rd_blocked) || (pg_req && pg_blocked && r.st == FBPE_IDLE && !er_req)
            || (er_req && er_blocked && r.st == FBPE_IDLE)) begin
            next_r.viol = 1'b1; // [R9]
        end
    end

    always_ff @(posedge mclk) begin
        if (reset) begin
            r <= '{st: FBPE_IDLE, blk: '0, off: '0, ro: PROT_RESET, xo: PROT_RESET,
                   viol: 1'b0, done: 1'b0, rvalid: 1'b0, rmask: 1'b0};
        end else begin
            r <= next_r;
        end
    end

    fbpe_array u_array (
        .mclk(mclk),
        .raddr(rd_addr),
        .rdata(arr_rdata),
        .we(arr_we),
        .waddr(arr_waddr),
        .wdata(arr_wdata)
    );

    // blocked read returns zero, hiding contents
    assign rd_data = r.rmask ? 32'h0000_0000 : arr_rdata; // [R7]
    assign rd_valid = r.rvalid;
    assign rd_denied = r.rvalid && r.rmask;
    assign busy = (r.st == FBPE_ERASE);
    assign done = r.done;
    assign ro_map = r.ro;
    assign xo_map = r.xo;
    assign viol = r.viol;

    property p_read_one_cycle;
        @(posedge mclk) disable iff (reset)
        (rd_req && rd_addr < WADDR_W'(NUM_WORDS)) |=> rd_valid;
    endproperty
    a_read_one_cycle: assert property (p_read_one_cycle) // [R8]
        else $error("read not answered next cycle");

    property p_xo_hidden;
        @(posedge mclk) disable iff (reset)
        (rd_req && rd_src != FBPE_SRC_FETCH && r.xo[gran_of(rd_addr)]) |=> (rd_data == 32'h0000_0000);
    endproperty
    a_xo_hidden: assert property (p_xo_hidden) // [R7]
        else $error("execute-only data leaked");

    property p_fetch_ok;
        @(posedge mclk) disable iff (reset)
        (rd_req && rd_src == FBPE_SRC_FETCH) |=> !rd_denied;
    endproperty
    a_fetch_ok: assert property (p_fetch_ok) // [R7]
        else $error("fetch wrongly denied");

    property p_no_write_protected;
        @(posedge mclk) disable iff (reset)
        arr_we |-> !(r.ro[arr_waddr[WADDR_W-1:GRAN_LSB]] || r.xo[arr_waddr[WADDR_W-1:GRAN_LSB]]);
    endproperty
    a_no_write_protected: assert property (p_no_write_protected) // [R5] [R6]
        else $error("write into protected granule");

    property p_erase_ones;
        @(posedge mclk) disable iff (reset)
        busy |-> (arr_we && arr_wdata == ERASED_WORD && arr_waddr[WADDR_W-1:BLK_LSB] == r.blk);
    endproperty
    a_erase_ones: assert property (p_erase_ones) // [R1] [R2]
        else $error("erase wrote non-ones or wrong block");

    property p_prog_violation;
        @(posedge mclk) disable iff (reset)
        (pg_req && pg_blocked && !busy && !er_req) |=> viol;
    endproperty
    a_prog_violation: assert property (p_prog_violation) // [R9]
        else $error("program violation not flagged");

    property p_erase_refused;
        @(posedge mclk) disable iff (reset)
        (er_req && er_blocked && !busy) |=> (!busy && viol);
    endproperty
    a_erase_refused: assert property (p_erase_refused) // [R5] [R6] [R9]
        else $error("protected erase not refused");

    property p_prot_update;
        @(posedge mclk) disable iff (reset)
        prot_wr |=> (ro_map[$past(prot_gran)] == $past(prot_ro)
                     && xo_map[$past(prot_gran)] == $past(prot_xo));
    endproperty
    a_prot_update: assert property (p_prot_update) // [R3] [R4]
        else $error("protection setting not stored");
endmodule
`default_nettype wire

// ==== tb/fbpe_cpu.sv ====
`timescale 1ns/1ps
`default_nettype none
module fbpe_cpu (
    input wire logic mclk,
    output logic rd_req,
    output logic [1:0] rd_src,
    output logic [fbpe_pkg::WADDR_W-1:0] rd_addr,
    input wire logic rd_valid,
    input wire logic [31:0] rd_data,
    input wire logic rd_denied,
    output logic pg_req,
    output logic [fbpe_pkg::WADDR_W-1:0] pg_addr,
    output logic [31:0] pg_data,
    output logic er_req,
    output logic [fbpe_pkg::BLK_W-1:0] er_block,
    input wire logic busy,
    input wire logic done
);
    import fbpe_pkg::*;

    initial begin
        {rd_req, pg_req, er_req, rd_src} = '0;
        {rd_addr, pg_addr, pg_data, er_block} = '0;
    end
    // released rd_addr, pg_data and er_block flip so a stale value never looks valid
    task automatic rd(input logic [1:0] s, input int a, output logic [31:0] q,
        output logic [1:0] f);
        @(posedge mclk);
        rd_req <= 1'b1;
        rd_src <= s;
        rd_addr <= a[WADDR_W-1:0];
        @(posedge mclk);
        rd_req <= 1'b0;
        rd_addr <= ~a[WADDR_W-1:0];
        #1;
        q = rd_data;
        f = {rd_valid, rd_denied};
    endtask
    task automatic pg(input int a, input logic [31:0] d, output logic ok);
        @(posedge mclk);
        pg_req <= 1'b1;
        pg_addr <= a[WADDR_W-1:0];
        pg_data <= d;
        @(posedge mclk);
        pg_req <= 1'b0;
        pg_data <= ~d;
        #1;
        ok = done;
    endtask
    task automatic er(input int b, output int n, output logic dn);
        @(posedge mclk);
        er_req <= 1'b1;
        er_block <= b[BLK_W-1:0];
        @(posedge mclk);
        er_req <= 1'b0;
        er_block <= ~b[BLK_W-1:0];
        #1;
        n = 0;
        dn = 1'b0;
        while (busy === 1'b1 && n < 300) begin
            @(posedge mclk);
            #1;
            n++;
        end
        // done pulses with the last write, so it stands as busy falls
        dn = done;
    endtask
endmodule
`default_nettype wire

// ==== tb/flash_block_protect_erase_tb.sv ====
`timescale 1ns/1ps
`default_nettype none
module flash_block_protect_erase_tb;
    import fbpe_pkg::*;
    logic mclk = 0, reset = 1, prot_wr = 0, prot_ro = 0, prot_xo = 0, viol_clr = 0;
    logic [GRAN_W-1:0] prot_gran = '0;
    logic rd_req, rd_valid, rd_denied, pg_req, er_req, busy, done, viol, ok, dn;
    logic [1:0] rd_src, f;
    logic [WADDR_W-1:0] rd_addr, pg_addr;
    logic [31:0] rd_data, pg_data, q;
    logic [BLK_W-1:0] er_block;
    logic [NUM_GRAN-1:0] ro_map, xo_map;
    int error_cnt = 0, cmp_count = 0, n;
    fbpe_flash_ctrl uut(.mclk, .reset, .rd_req, .rd_src, .rd_addr, .rd_valid, .rd_data,
        .rd_denied, .pg_req, .pg_addr, .pg_data, .er_req, .er_block, .busy, .done,
        .prot_wr, .prot_gran, .prot_ro, .prot_xo, .ro_map, .xo_map, .viol, .viol_clr);
    fbpe_cpu cpu(.mclk, .rd_req, .rd_src, .rd_addr, .rd_valid, .rd_data, .rd_denied,
        .pg_req, .pg_addr, .pg_data, .er_req, .er_block, .busy, .done);
    initial begin
        forever #4 mclk = ~mclk;
    end
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        cmp_count++;
        if (g !== e) begin
            error_cnt++;
            $display("[ERR] %0t got %h expected %h", $time, g, e);
        end
    endtask
    task automatic pulse(input logic c, input int g, input logic r, input logic x);
        @(posedge mclk);
        prot_wr <= ~c;
        viol_clr <= c;
        prot_gran <= g[GRAN_W-1:0];
        prot_ro <= r;
        prot_xo <= x;
        @(posedge mclk);
        {prot_wr, viol_clr} <= 2'b00;
        #1;
    endtask
    task automatic t_erase;
        cpu.pg(768, 32'h1234_5678, ok);
        chk(ok, 1);
        cpu.er(2, n, dn);
        chk(n, 256);
        chk(dn, 1);
        cpu.rd(0, 512, q, f);
        chk(q, ERASED_WORD);
        chk(f, 2'b10);
        cpu.rd(1, 767, q, f);
        chk(q, ERASED_WORD);
        cpu.rd(1, 768, q, f);
        chk(q, 32'h1234_5678);
        cpu.rd(0, 24576, q, f);
        chk(f, 2'b00);
    endtask
    task automatic t_ro;
        pulse(0, 1, 1, 0);
        chk({ro_map[2:0], xo_map[1]}, 4'b0100);
        cpu.pg(769, 32'h0, ok);
        chk({ok, viol}, 2'b01);
        pulse(1, 0, 0, 0);
        cpu.er(3, n, dn);
        chk({n[8:0], viol}, 10'h001);
        cpu.rd(2, 768, q, f);
        chk(q, 32'h1234_5678);
        cpu.er(4, n, dn);
        chk(n, 256);
        pulse(1, 0, 0, 0);
    endtask
    task automatic t_xo;
        pulse(0, 1, 0, 1);
        chk({ro_map[1], xo_map[1]}, 2'b01);
        cpu.pg(768, 32'h0, ok);
        cpu.er(2, n, dn);
        chk({ok, n[8:0]}, 10'h000);
        cpu.rd(0, 768, q, f);
        chk({q, f}, {32'h1234_5678, 2'b10});
        for (int s = 1; s < 3; s++) begin
            pulse(1, 0, 0, 0);
            cpu.rd(s[1:0], 768, q, f);
            chk({q, f}, {32'h0, 2'b11});
            @(posedge mclk);
            #1;
            chk(viol, 1);
        end
    endtask
    task automatic give_verdict;
        if (error_cnt == 0 && cmp_count > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    initial begin
        repeat (2) @(posedge mclk);
        reset <= 1'b0;
        @(posedge mclk);
        #1;
        chk(32'({busy, viol, |ro_map, |xo_map}), 32'h0000_0000);
        t_erase();
        t_ro();
        t_xo();
        give_verdict();
    end
    initial begin
        #20000;
        error_cnt++;
        give_verdict();
    end
endmodule
`default_nettype wire
